// ---- design/gpp_pkg.sv ----
// package: register offsets, masks and reset values for the gpio port pair
package gpp_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] GPP_P0_LATCH_OFF   = 4'h0;
  localparam logic [3:0] GPP_P0_DIR_OFF     = 4'h1;
  localparam logic [3:0] GPP_P0_PULLUP_OFF  = 4'h2;
  localparam logic [3:0] GPP_AIN_DIS_OFF    = 4'h3;
  localparam logic [3:0] GPP_P1_LATCH_OFF   = 4'h4;
  localparam logic [3:0] GPP_P1_DIR_OFF     = 4'h5;
  localparam logic [3:0] GPP_STBY_CTRL_OFF  = 4'h6;
  // implemented bit masks
  localparam logic [7:0] GPP_AIN_MASK       = 8'h3f;
  localparam logic [7:0] GPP_P1_MASK        = 8'hf4;
  // default open-drain set on port one
  localparam logic [7:0] GPP_P1_OD_DEFAULT  = 8'hf0;
  // external interrupt capable pins of port zero
  localparam logic [7:0] GPP_IRQ_PIN_MASK   = 8'hfc;
  // reset values
  localparam logic [7:0] GPP_RST_BYTE       = 8'h00;
  // standby control field position
  localparam int         GPP_STBY_FLOAT_BIT = 0;
endpackage : gpp_pkg

// ---- design/gpp_port_pair.sv ----
// module: gpio logic for port zero and port one with analog sharing
`timescale 1ns/1ns
`default_nettype none
module gpp_port_pair #(
  parameter logic [7:0] P1_OPEN_DRAIN = gpp_pkg::GPP_P1_OD_DEFAULT
) (
  input  wire logic       mclk_i,          // system clock
  input  wire logic       rst_i,           // sync reset, high
  input  wire logic [3:0] reg_addr_i,      // register address
  input  wire logic [7:0] reg_wdata_i,     // write data
  input  wire logic       reg_wr_i,        // write strobe
  input  wire logic       reg_rd_i,        // read strobe
  input  wire logic       reg_rmw_i,       // read is read-modify-write
  output logic      [7:0] reg_rdata_o,     // read data, one cycle later
  input  wire logic       standby_i,       // stop or watch mode active
  input  wire logic [7:0] p0_pin_i,        // port zero pin levels
  output logic      [7:0] p0_pin_o,        // port zero drive level
  output logic      [7:0] p0_pin_oe_o,     // port zero drive enable
  output logic      [7:0] p0_pullup_o,     // port zero pull-up connect
  input  wire logic [7:0] p0_periph_oe_i,  // peripheral output enables
  input  wire logic [7:0] p0_periph_do_i,  // peripheral output data
  output logic      [7:0] p0_din_o,        // gated digital input to peripherals
  output logic      [7:0] p0_ain_en_o,     // analog input enables
  input  wire logic [7:0] irq_en_i,        // external interrupt enables
  output logic      [7:0] irq_pin_o,       // levels to interrupt circuit
  input  wire logic [7:0] p1_pin_i,        // port one pin levels
  output logic      [7:0] p1_pin_o,        // port one drive level
  output logic      [7:0] p1_pin_oe_o,     // port one drive enable
  input  wire logic [7:0] p1_periph_oe_i,  // peripheral output enables
  input  wire logic [7:0] p1_periph_do_i,  // peripheral output data
  output logic      [7:0] p1_din_o         // gated digital input port one
);

  // complete state of the block
  typedef struct packed {
    logic [7:0] p0_latch;    // port0_output_latch
    logic [7:0] p0_dir;      // port0_direction
    logic [7:0] p0_pull;     // port0_pullup_enable
    logic [7:0] ain_dis;     // analog_input_disable_low
    logic [7:0] p1_latch;    // port1_output_latch
    logic [7:0] p1_dir;      // port1_direction
    logic [7:0] stby_ctrl;   // standby_control, bit0 standby_pin_float
    logic [7:0] rdata;       // registered read data
    logic [7:0] p0_s1;       // pin sync stage one
    logic [7:0] p0_s2;       // pin sync stage two
    logic [7:0] p0_s3;       // pin sync stage three
    logic [7:0] p0_lvl;      // accepted pin level
    logic [7:0] p1_s1;       // port one sync stage one
    logic [7:0] p1_s2;       // port one sync stage two
    logic [7:0] p1_s3;       // port one sync stage three
    logic [7:0] p1_lvl;      // port one accepted level
  } gpp_state_type;

  gpp_state_type s_q;  // registered state
  gpp_state_type s_d;  // next state

  logic       float_en;   // pins forced to high impedance
  logic [7:0] p0_drv_en;  // port zero pin driven
  logic [7:0] p0_drv_lv;  // port zero level when driven
  logic [7:0] p1_drv_en;
  logic [7:0] p1_drv_lv;
  logic [7:0] p0_dig_en;  // digital input path enabled
  logic [7:0] p0_blk;     // input blocked in standby
  logic [7:0] p1_blk;
  logic [7:0] p0_in_lvl;  // port zero level behind the input gate
  logic [7:0] p1_in_lvl;  // port one level behind the input gate

  // standby float: only when float bit set
  // standby pin control
  assign float_en = standby_i & s_q.stby_ctrl[gpp_pkg::GPP_STBY_FLOAT_BIT];

  // per-pin drive and input gating
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pin
      assign p0_drv_lv[gi] = p0_periph_oe_i[gi] ? p0_periph_do_i[gi] : s_q.p0_latch[gi];
      assign p0_drv_en[gi] = (p0_periph_oe_i[gi] | s_q.p0_dir[gi]) & ~float_en;
      // only implemented pins, open-drain floats high
      assign p1_drv_lv[gi] = p1_periph_oe_i[gi] ? p1_periph_do_i[gi] : s_q.p1_latch[gi];
      assign p1_drv_en[gi] = (p1_periph_oe_i[gi] | s_q.p1_dir[gi]) & ~float_en
                             & gpp_pkg::GPP_P1_MASK[gi]
                             & ~(P1_OPEN_DRAIN[gi] & p1_drv_lv[gi]);
      // digital input on pins 0 to 5 only with disable bit set, pins 6 and 7 always
      assign p0_dig_en[gi] = gpp_pkg::GPP_AIN_MASK[gi] ? s_q.ain_dis[gi] : 1'b1;
      // enabled interrupt pins stay open in standby
      assign p0_blk[gi] = float_en & ~(gpp_pkg::GPP_IRQ_PIN_MASK[gi] & irq_en_i[gi]);
      assign p1_blk[gi] = float_en;
    end
  endgenerate

  // next-state logic: registers, synchronisers, read mux
  always_comb
  begin
    s_d = s_q;
    // three-stage pin sync, accept when stages two and three agree
    s_d.p0_s1 = p0_pin_i;
    s_d.p0_s2 = s_q.p0_s1;
    s_d.p0_s3 = s_q.p0_s2;
    s_d.p0_lvl = (s_q.p0_s2 & s_q.p0_s3) | (s_q.p0_lvl & (s_q.p0_s2 | s_q.p0_s3));
    s_d.p1_s1 = p1_pin_i;
    s_d.p1_s2 = s_q.p1_s1;
    s_d.p1_s3 = s_q.p1_s2;
    s_d.p1_lvl = (s_q.p1_s2 & s_q.p1_s3) | (s_q.p1_lvl & (s_q.p1_s2 | s_q.p1_s3));
    s_d.rdata = gpp_pkg::GPP_RST_BYTE;
    // writes land in the addressed register; port data writes go to the latch whatever the direction
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        gpp_pkg::GPP_P0_LATCH_OFF:  s_d.p0_latch = reg_wdata_i;
        gpp_pkg::GPP_P0_DIR_OFF:    s_d.p0_dir = reg_wdata_i;
        gpp_pkg::GPP_P0_PULLUP_OFF: s_d.p0_pull = reg_wdata_i;
        // no analog bits for pins 6 and 7
        gpp_pkg::GPP_AIN_DIS_OFF:   s_d.ain_dis = reg_wdata_i & gpp_pkg::GPP_AIN_MASK;
        // unused port one bits stay zero
        gpp_pkg::GPP_P1_LATCH_OFF:  s_d.p1_latch = reg_wdata_i & gpp_pkg::GPP_P1_MASK;
        gpp_pkg::GPP_P1_DIR_OFF:    s_d.p1_dir = reg_wdata_i & gpp_pkg::GPP_P1_MASK;
        gpp_pkg::GPP_STBY_CTRL_OFF:
          s_d.stby_ctrl[gpp_pkg::GPP_STBY_FLOAT_BIT] = reg_wdata_i[gpp_pkg::GPP_STBY_FLOAT_BIT];
        default: ;  // unmapped writes ignored
      endcase
    end
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        // output pins read latch, others pin unless rmw
        gpp_pkg::GPP_P0_LATCH_OFF:
          s_d.rdata = reg_rmw_i ? s_q.p0_latch
                    : ((s_q.p0_latch & s_q.p0_dir & ~p0_periph_oe_i)
                       | (p0_in_lvl & ~(s_q.p0_dir & ~p0_periph_oe_i)));
        gpp_pkg::GPP_P0_DIR_OFF:    s_d.rdata = s_q.p0_dir;
        gpp_pkg::GPP_P0_PULLUP_OFF: s_d.rdata = s_q.p0_pull;
        gpp_pkg::GPP_AIN_DIS_OFF:   s_d.rdata = s_q.ain_dis;
        gpp_pkg::GPP_P1_LATCH_OFF:
          s_d.rdata = reg_rmw_i ? s_q.p1_latch
                    : (((s_q.p1_latch & s_q.p1_dir & ~p1_periph_oe_i)
                       | (p1_in_lvl & ~(s_q.p1_dir & ~p1_periph_oe_i)))
                       & gpp_pkg::GPP_P1_MASK);
        gpp_pkg::GPP_P1_DIR_OFF:    s_d.rdata = s_q.p1_dir;
        gpp_pkg::GPP_STBY_CTRL_OFF: s_d.rdata = s_q.stby_ctrl;
        default:                    s_d.rdata = gpp_pkg::GPP_RST_BYTE;
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // pin and peripheral outputs
  assign reg_rdata_o = s_q.rdata;
  assign p0_pin_o    = p0_drv_lv;
  assign p0_pin_oe_o = p0_drv_en;
  assign p1_pin_o    = p1_drv_lv;
  assign p1_pin_oe_o = p1_drv_en;
  assign p0_pullup_o = s_q.p0_pull & ~(p0_drv_en & ~p0_drv_lv);
  // gated digital input, held low when blocked
  // unused port one positions carry no input
  assign p0_in_lvl   = s_q.p0_lvl & p0_dig_en & ~p0_blk;
  assign p1_in_lvl   = s_q.p1_lvl & gpp_pkg::GPP_P1_MASK & ~p1_blk;
  assign p0_din_o    = p0_in_lvl;
  assign p1_din_o    = p1_in_lvl;
  // analog enabled when disable bit is zero
  assign p0_ain_en_o = ~s_q.ain_dis & gpp_pkg::GPP_AIN_MASK;
  // interrupt pins see the level unless blocked in standby float
  assign irq_pin_o   = s_q.p0_lvl & gpp_pkg::GPP_IRQ_PIN_MASK & ~(p0_blk);

  property p_dir_drive;
    @(posedge mclk_i) disable iff (rst_i)
      (!standby_i && p0_periph_oe_i == 8'h00) |-> (p0_pin_oe_o == s_q.p0_dir);
  endproperty
  a_dir_drive: assert property (p_dir_drive) else $error("drive enable differs from direction");

  property p_latch_drive;
    @(posedge mclk_i) disable iff (rst_i)
      (p0_periph_oe_i == 8'h00) |-> (p0_pin_o == s_q.p0_latch);
  endproperty
  a_latch_drive: assert property (p_latch_drive) else $error("pin level differs from latch");

  property p_write_latch;
    @(posedge mclk_i) disable iff (rst_i)
      (reg_wr_i && reg_addr_i == gpp_pkg::GPP_P0_LATCH_OFF) |=> (s_q.p0_latch == $past(reg_wdata_i));
  endproperty
  a_write_latch: assert property (p_write_latch) else $error("latch not written");

  property p_rmw_read;
    @(posedge mclk_i) disable iff (rst_i)
      (reg_rd_i && reg_rmw_i && reg_addr_i == gpp_pkg::GPP_P0_LATCH_OFF && !reg_wr_i)
        |=> (reg_rdata_o == s_q.p0_latch);
  endproperty
  a_rmw_read: assert property (p_rmw_read) else $error("rmw read not latch");

  property p_reset_dir;
    @(posedge mclk_i) rst_i |=> (s_q.p0_dir == 8'h00 && s_q.ain_dis == 8'h00 && s_q.p1_dir == 8'h00);
  endproperty
  a_reset_dir: assert property (p_reset_dir) else $error("reset did not clear");

  property p_float;
    @(posedge mclk_i) disable iff (rst_i)
      float_en |-> (p0_pin_oe_o == 8'h00 && p1_pin_oe_o == 8'h00);
  endproperty
  a_float: assert property (p_float) else $error("pin driven during standby float");

  property p_pullup;
    @(posedge mclk_i) disable iff (rst_i)
      (p0_pin_oe_o & ~p0_pin_o & p0_pullup_o) == 8'h00;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up on while driving low");

  property p_unused;
    @(posedge mclk_i) disable iff (rst_i)
      ((s_q.ain_dis & ~gpp_pkg::GPP_AIN_MASK) == 8'h00)
      && ((s_q.p1_dir & ~gpp_pkg::GPP_P1_MASK) == 8'h00);
  endproperty
  a_unused: assert property (p_unused) else $error("unimplemented bit set");

  property p_open_drain;
    @(posedge mclk_i) disable iff (rst_i)
      (P1_OPEN_DRAIN & p1_pin_o & p1_pin_oe_o) == 8'h00;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain pin driven high");

  property p_p1_dir_drive;
    @(posedge mclk_i) disable iff (rst_i)
      (!standby_i && p1_periph_oe_i == 8'h00)
        |-> (p1_pin_oe_o == (s_q.p1_dir & ~(P1_OPEN_DRAIN & p1_pin_o)));
  endproperty
  a_p1_dir_drive: assert property (p_p1_dir_drive) else $error("port one enable wrong");

  property p_p1_latch_drive;
    @(posedge mclk_i) disable iff (rst_i)
      (p1_periph_oe_i == 8'h00) |-> (p1_pin_o == s_q.p1_latch);
  endproperty
  a_p1_latch_drive: assert property (p_p1_latch_drive) else $error("port one level wrong");

  property p_read_out;
    @(posedge mclk_i) disable iff (rst_i)
      (reg_rd_i && !reg_rmw_i && !reg_wr_i && reg_addr_i == gpp_pkg::GPP_P0_LATCH_OFF
       && p0_periph_oe_i == 8'h00 && s_q.p0_dir == 8'hff)
        |=> (reg_rdata_o == s_q.p0_latch);
  endproperty
  a_read_out: assert property (p_read_out) else $error("output read not latch");

  property p_periph_drive;
    @(posedge mclk_i) disable iff (rst_i)
      !standby_i |-> (((p0_pin_oe_o & p0_periph_oe_i) == p0_periph_oe_i)
                      && (((p0_pin_o ^ p0_periph_do_i) & p0_periph_oe_i) == 8'h00));
  endproperty
  a_periph_drive: assert property (p_periph_drive) else $error("peripheral not driving");

  property p_analog_gate;
    @(posedge mclk_i) disable iff (rst_i)
      (p0_din_o & ~s_q.ain_dis & gpp_pkg::GPP_AIN_MASK) == 8'h00;
  endproperty
  a_analog_gate: assert property (p_analog_gate) else $error("input on analog pin");

  property p_block;
    @(posedge mclk_i) disable iff (rst_i)
      float_en |-> ((p0_din_o & ~(irq_en_i & gpp_pkg::GPP_IRQ_PIN_MASK)) == 8'h00
                    && p1_din_o == 8'h00);
  endproperty
  a_block: assert property (p_block) else $error("blocked input not low");

  property p_keep;
    @(posedge mclk_i) disable iff (rst_i)
      (standby_i && !s_q.stby_ctrl[gpp_pkg::GPP_STBY_FLOAT_BIT] && p0_periph_oe_i == 8'h00)
        |-> (p0_pin_oe_o == s_q.p0_dir);
  endproperty
  a_keep: assert property (p_keep) else $error("standby changed drive");

  property p_irq_feed;
    @(posedge mclk_i) disable iff (rst_i)
      !float_en |-> (irq_pin_o == (s_q.p0_lvl & gpp_pkg::GPP_IRQ_PIN_MASK));
  endproperty
  a_irq_feed: assert property (p_irq_feed) else $error("interrupt level wrong");

  property p_pullup_on;
    @(posedge mclk_i) disable iff (rst_i)
      (p0_pin_oe_o == 8'h00) |-> (p0_pullup_o == s_q.p0_pull);
  endproperty
  a_pullup_on: assert property (p_pullup_on) else $error("pull-up not connected");

  property p_read_pin;
    @(posedge mclk_i) disable iff (rst_i)
      (reg_rd_i && !reg_rmw_i && !reg_wr_i && reg_addr_i == gpp_pkg::GPP_P0_LATCH_OFF
       && s_q.p0_dir == 8'h00 && p0_periph_oe_i == 8'h00 && !float_en
       && s_q.ain_dis == gpp_pkg::GPP_AIN_MASK)
        |=> (reg_rdata_o == $past(s_q.p0_lvl));
  endproperty
  a_read_pin: assert property (p_read_pin) else $error("input read not pin level");

  property p_rmw_p1;
    @(posedge mclk_i) disable iff (rst_i)
      (reg_rd_i && reg_rmw_i && reg_addr_i == gpp_pkg::GPP_P1_LATCH_OFF && !reg_wr_i)
        |=> (reg_rdata_o == s_q.p1_latch);
  endproperty
  a_rmw_p1: assert property (p_rmw_p1) else $error("port one rmw read not latch");

endmodule : gpp_port_pair
`default_nettype wire

// ---- tb/gpp_pin_model.sv ----
// board side of one gpio port: drivers, pull-ups and external levels
`timescale 1ns/1ns
`default_nettype none
module gpp_pin_model (
  input  wire logic [7:0] drv_i,   // level driven by the port
  input  wire logic [7:0] oe_i,    // port drive enables
  input  wire logic [7:0] pu_i,    // pull-up connects
  input  wire logic [7:0] board_i, // level forced by the board
  output logic      [7:0] pin_o    // resolved wire level
);
  // released line takes the pull-up or board level
  // driver wins, then pull-up, then board level
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      pin_o[i] = oe_i[i] ? drv_i[i] : (pu_i[i] ? 1'b1 : board_i[i]);
  end
endmodule : gpp_pin_model
`default_nettype wire

// ---- tb/tb_gpp_port_pair.sv ----
// self-checking testbench for the gpio port pair
`timescale 1ns/1ns
`default_nettype none
module tb_gpp_port_pair;
  logic       mclk_i = 1'b0;  // system clock
  logic       rst_i  = 1'b1;  // sync reset
  logic [3:0] addr   = 4'h0;  // register address
  logic [7:0] wdat   = 8'h00; // write data
  logic       wr = 1'b0, rd = 1'b0, read_modify_write_access = 1'b0, stby = 1'b0;
  logic [7:0] poe0 = 8'h00, pdo0 = 8'h00, poe1 = 8'h00, pdo1 = 8'h00;
  logic [7:0] irqen = 8'h00, brd0 = 8'h00, brd1 = 8'h00;
  logic [7:0] rdat, p0o, p0oe, p0pu, p0din, ain, irqp, p1o, p1oe, p1din, p0pin, p1pin;
  int         n_errors = 0;   // mismatches
  int         tests_run = 0;  // comparisons
  int         cyc = 0;        // cycle count for timeout

  // clock at 50 MHz
  always #10 mclk_i = ~mclk_i;

  gpp_port_pair gpp_port_pair_inst (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rmw_i(read_modify_write_access), .reg_rdata_o(rdat),
    .standby_i(stby), .p0_pin_i(p0pin), .p0_pin_o(p0o), .p0_pin_oe_o(p0oe),
    .p0_pullup_o(p0pu), .p0_periph_oe_i(poe0), .p0_periph_do_i(pdo0), .p0_din_o(p0din),
    .p0_ain_en_o(ain), .irq_en_i(irqen), .irq_pin_o(irqp), .p1_pin_i(p1pin),
    .p1_pin_o(p1o), .p1_pin_oe_o(p1oe), .p1_periph_oe_i(poe1), .p1_periph_do_i(pdo1),
    .p1_din_o(p1din));
  gpp_pin_model gpp_pin_model_inst (.drv_i(p0o), .oe_i(p0oe), .pu_i(p0pu),
    .board_i(brd0), .pin_o(p0pin));
  gpp_pin_model gpp_pin_model_inst_p1 (.drv_i(p1o), .oe_i(p1oe), .pu_i(8'h00),
    .board_i(brd1), .pin_o(p1pin));

  // hang guard
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle write strobe
  task automatic wrr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdat <= d;
    wr   <= 1'b1;
    @(posedge mclk_i);
    wr   <= 1'b0;
  endtask : wrr

  // one-cycle read strobe, data judged in the following cycle
  task automatic rdc(input logic [3:0] a, input logic m, input logic [7:0] exp);
    @(posedge mclk_i);
    addr <= a;
    read_modify_write_access  <= m;
    rd   <= 1'b1;
    @(posedge mclk_i);
    rd   <= 1'b0;
    read_modify_write_access  <= 1'b0;
    #1 chk(rdat, exp);
  endtask : rdc

  // lets pin synchronisers catch up
  task automatic settle;
    repeat (6) @(posedge mclk_i);
    #1;
  endtask : settle

  task automatic t_reset;
    for (int a = 0; a < 8; a++)
      rdc(a[3:0], 1'b0, 8'h00);
    chk(p0oe, 8'h00);
    chk(ain, 8'h3f);
  endtask : t_reset

  task automatic t_analog;
    wrr(4'h1, 8'h00);
    wrr(4'h2, 8'h00);
    @(posedge mclk_i);
    brd0 <= 8'hff;
    settle();
    chk(p0din & 8'h3f, 8'h00);
    chk(irqp & 8'hfc, 8'hfc);
    rdc(4'h0, 1'b0, 8'hc0);
    wrr(4'h3, 8'hff);
    rdc(4'h3, 1'b0, 8'h3f);
    settle();
    chk(ain, 8'h00);
    chk(p0din, 8'hff);
  endtask : t_analog

  task automatic t_dir;
    @(posedge mclk_i);
    poe0 <= 8'h00;
    brd0 <= 8'h5a;
    wrr(4'h0, 8'ha5);
    settle();
    chk(p0oe, 8'h00);
    rdc(4'h0, 1'b0, 8'h5a);
    rdc(4'h0, 1'b1, 8'ha5);
    wrr(4'h1, 8'hff);
    settle();
    chk(p0oe, 8'hff);
    chk(p0o, 8'ha5);
    rdc(4'h0, 1'b0, 8'ha5);
  endtask : t_dir

  task automatic t_periph;
    @(posedge mclk_i);
    poe0 <= 8'h0f;
    pdo0 <= 8'h03;
    settle();
    chk(p0o, 8'ha3);
    chk(p0oe, 8'hff);
    rdc(4'h0, 1'b0, 8'ha3);
    rdc(4'h0, 1'b1, 8'ha5);
    @(posedge mclk_i);
    poe0 <= 8'h00;
  endtask : t_periph

  task automatic t_pull_stby;
    wrr(4'h0, 8'h0f);
    wrr(4'h2, 8'hff);
    settle();
    chk(p0pu, 8'h0f);
    wrr(4'h2, 8'h00);
    wrr(4'h6, 8'h01);
    irqen <= 8'h0c;
    brd0 <= 8'hff;
    stby <= 1'b1;
    settle();
    chk(p0oe, 8'h00);
    chk(p0din, 8'h0c);
    rdc(4'h6, 1'b0, 8'h01);
    @(posedge mclk_i);
    stby <= 1'b0;
    wrr(4'h6, 8'h00);
    stby <= 1'b1;
    settle();
    chk(p0oe, 8'hff);
    chk(p0o, 8'h0f);
    @(posedge mclk_i);
    stby <= 1'b0;
    irqen <= 8'h00;
  endtask : t_pull_stby

  task automatic t_port1;
    wrr(4'h5, 8'hff);
    rdc(4'h5, 1'b0, 8'hf4);
    wrr(4'h4, 8'hff);
    rdc(4'h4, 1'b1, 8'hf4);
    settle();
    chk(p1oe, 8'h04);
    chk(p1o, 8'hf4);
    wrr(4'h4, 8'h00);
    settle();
    chk(p1oe, 8'hf4);
    chk(p1o, 8'h00);
    @(posedge mclk_i);
    brd1 <= 8'hff;
    wrr(4'h5, 8'h00);
    settle();
    rdc(4'h4, 1'b0, 8'hf4);
    chk(p1din, 8'hf4);
    @(posedge mclk_i);
    poe1 <= 8'h04;
    pdo1 <= 8'h00;
    settle();
    chk(p1oe, 8'h04);
    rdc(4'h4, 1'b0, 8'hf0);
    rdc(4'h4, 1'b1, 8'h00);
    @(posedge mclk_i);
    poe1 <= 8'h00;
  endtask : t_port1

  task automatic t_rerst;
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    rdc(4'h1, 1'b0, 8'h00);
    rdc(4'h3, 1'b0, 8'h00);
    chk(p0oe, 8'h00);
    chk(ain, 8'h3f);
  endtask : t_rerst

  task automatic finish_test;
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  // main sequence
  initial
  begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_reset();
    t_analog();
    t_dir();
    t_periph();
    t_pull_stby();
    t_port1();
    t_rerst();
    finish_test();
  end
endmodule : tb_gpp_port_pair
`default_nettype wire
